//--- emc_defines.svh
// Constants of the external memory controller pin block
`ifndef EMC_DEFINES_SVH
`define EMC_DEFINES_SVH
`define EMC_NUM_CS        8
`define EMC_NUM_LANES     8
`define EMC_NUM_GPL       6
`define EMC_WAVE_DEPTH    16
`define EMC_BANK_SHIFT    29
`define EMC_CS_TIMEOUT    8'hff
`define EMC_BCTL_NORMAL   2'h0
`define EMC_BCTL_SWAP     2'h1
`define EMC_BCTL_OFF      2'h2
`define EMC_SD_TRCD       4'h2
`define EMC_SD_TCL        4'h2
`endif

//--- emc_pkg.sv
// Types of the external memory controller pin block
package emc_pkg;
  typedef enum logic [1:0] {EMC_M_GPCS, EMC_M_SDRAM, EMC_M_PROG} emc_mach_t;
  typedef enum logic [1:0] {EMC_SZ_BYTE, EMC_SZ_HALF, EMC_SZ_WORD,
                            EMC_SZ_DWORD} emc_size_t;
endpackage

//--- emc_lane_decode.sv
// Byte-lane decode from address, transfer size and port size
`include "emc_defines.svh"
module emc_lane_decode
(
  input  wire logic [2:0]       i_addr_low,
  input  wire emc_pkg::emc_size_t i_size,
  input  wire logic [1:0]       i_port_size,
  output logic      [7:0]       o_lanes
);
  function automatic logic [7:0] lane_mask(input logic [2:0] a,
                                           input logic [1:0] sz,
                                           input logic [1:0] ps);
    logic [7:0] base;
    logic [1:0] eff;
    base = 8'h00;
    eff = (sz > ps) ? ps : sz;
    unique case (eff)
      2'h0: base = 8'h01;
      2'h1: base = 8'h03;
      2'h2: base = 8'h0f;
      2'h3: base = 8'hff;
    endcase
    return base << a;
  endfunction

  always_comb
  begin
    o_lanes = lane_mask(i_addr_low, i_size, i_port_size);
  end
endmodule

//--- emc_core.sv
// External memory controller: chip-select, SDRAM and programmable machines
// Operation
// - Eight chip-select outputs, each enabling one attached device.
// - Two data buffer controls, behaviour chosen by buffer config field.
// - Burst address bits 3 and 4 registered to memories during an access.
// - Address latch enable driven in external-master configuration.
// - Eight write lane enables, only written lanes asserted.
// - Eight SDRAM lane masks select participating byte lanes.
// - Programmable lane selects follow waveform, address, size, port size.
// - SDRAM A10 is row bit for row, command bit for column.
// - Six programmable lines driven from the waveform pattern.
// - SDRAM write, row and column strobes to SDRAM command inputs.
// - Output enable turns on memory output buffers during chip-select machine reads.
// - Termination input ends a chip-select access; needs pull-up.
// - Wait input high suspends the programmable waveform until low.
// - Parity lane select acts as byte select of parity chip.
// - Address multiplexer control steers row/column in external master.
`include "emc_defines.svh"
module emc_core
(
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_req,
  input  wire logic [31:0]          i_addr,
  input  wire logic                 i_write,
  input  wire emc_pkg::emc_size_t   i_size,
  input  wire logic                 i_ext_master,
  input  wire logic [1:0]           i_buffer_ctl_config_field,
  input  wire logic [15:0]          i_bank_machine,
  input  wire logic [15:0]          i_bank_port_size,
  input  wire logic [7:0]           i_parity_en,
  input  wire logic [8:0]           i_wave_mem [`EMC_WAVE_DEPTH],
  input  wire logic                 i_gp_transfer_done_in,
  input  wire logic                 i_prog_wait_in,
  output logic                      o_busy,
  output logic                      o_done,
  output logic [7:0]                o_chip_sel_n,
  output logic                      o_buffer_ctl_zero,
  output logic                      o_buffer_ctl_one,
  output logic [1:0]                o_burst_addr_out,
  output logic                      o_addr_latch_en,
  output logic [7:0]                o_gp_write_lane_en_n,
  output logic [7:0]                o_sdram_lane_mask,
  output logic [7:0]                o_prog_lane_select_n,
  output logic                      o_sdram_addr_bit_ten,
  output logic [5:0]                o_prog_line,
  output logic                      o_sdram_write_strobe_n,
  output logic                      o_sdram_row_strobe_n,
  output logic                      o_sdram_col_strobe_n,
  output logic                      o_gp_output_en_n,
  output logic                      o_parity_lane_select_n,
  output logic                      o_sdram_addr_mux_ctl
);
  // ----------------------------------------------------------------
  // Transfer capture and bank decode
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_GPCS, S_ROW, S_COL, S_PROG,
                            S_END} emc_state_t;
  emc_state_t state;
  logic [2:0]  bank;
  logic [31:0] addr;
  logic        wr;
  emc_pkg::emc_size_t size;
  logic [7:0]  lanes;
  logic [7:0]  cnt;
  logic [3:0]  wave_ptr;
  logic [8:0]  wave_word;

  function automatic logic [2:0] bank_of(input logic [31:0] a);
    return a[31:`EMC_BANK_SHIFT];
  endfunction

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      addr <= 32'h0;
      wr   <= 1'b0;
      size <= emc_pkg::EMC_SZ_BYTE;
      bank <= 3'h0;
    end
    else if (state == S_IDLE && i_req)
    begin
      addr <= i_addr;
      wr   <= i_write;
      size <= i_size;
      bank <= bank_of(i_addr);
    end
  end

  emc_lane_decode u_lanes
  (
    .i_addr_low  (addr[2:0]),
    .i_size      (size),
    .i_port_size (i_bank_port_size[bank*2 +: 2]),
    .o_lanes     (lanes)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign wave_word = i_wave_mem[wave_ptr];

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      state    <= S_IDLE;
      cnt      <= 8'h0;
      wave_ptr <= 4'h0;
    end
    else
    begin
      unique case (state)
        S_IDLE:
          if (i_req)
          begin
            cnt      <= 8'h0;
            wave_ptr <= 4'h0;
            unique case (emc_pkg::emc_mach_t'(
                         i_bank_machine[bank_of(i_addr)*2 +: 2]))
              emc_pkg::EMC_M_SDRAM: state <= S_ROW;
              emc_pkg::EMC_M_PROG:  state <= S_PROG;
              default:              state <= S_GPCS;
            endcase
          end
        S_GPCS:
        begin
          cnt <= cnt + 8'h1;
          if (!i_gp_transfer_done_in || cnt == `EMC_CS_TIMEOUT)
            state <= S_END;
        end
        S_ROW:
        begin
          cnt <= cnt + 8'h1;
          if (cnt[3:0] == `EMC_SD_TRCD)
          begin
            cnt   <= 8'h0;
            state <= S_COL;
          end
        end
        S_COL:
        begin
          cnt <= cnt + 8'h1;
          if (cnt[3:0] == `EMC_SD_TCL)
            state <= S_END;
        end
        S_PROG:
          if (!i_prog_wait_in)
          begin
            wave_ptr <= wave_ptr + 4'h1;
            if (wave_word[8] || wave_ptr == 4'(`EMC_WAVE_DEPTH - 1))
              state <= S_END;
          end
        S_END:
          state <= S_IDLE;
      endcase
    end
  end

  assign o_busy = (state != S_IDLE);
  assign o_done = (state == S_END);

  // ----------------------------------------------------------------
  // Pin registers
  // ----------------------------------------------------------------
  logic act;
  assign act = (state == S_GPCS) || (state == S_ROW) || (state == S_COL)
               || (state == S_PROG);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_chip_sel_n           <= 8'hff;
      o_gp_write_lane_en_n   <= 8'hff;
      o_gp_output_en_n       <= 1'b1;
      o_sdram_lane_mask      <= 8'hff;
      o_prog_lane_select_n   <= 8'hff;
      o_parity_lane_select_n <= 1'b1;
      o_burst_addr_out       <= 2'h0;
    end
    else
    begin
      o_chip_sel_n <= act ? ~(8'h01 << bank) : 8'hff;
      o_gp_write_lane_en_n <= (state == S_GPCS && wr) ? ~lanes
                              : 8'hff;
      o_gp_output_en_n <= !(state == S_GPCS && !wr);
      o_sdram_lane_mask <= (state == S_COL) ? ~lanes : 8'hff;
      o_prog_lane_select_n <= (state == S_PROG && wave_word[7])
                              ? ~lanes : 8'hff;
      o_parity_lane_select_n <= !(act && i_parity_en[bank]);
      o_burst_addr_out <= act ? addr[4:3] : 2'h0;
    end
  end

  // SDRAM command: row activates, column issues read/write
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_sdram_row_strobe_n   <= 1'b1;
      o_sdram_col_strobe_n   <= 1'b1;
      o_sdram_write_strobe_n <= 1'b1;
      o_sdram_addr_bit_ten   <= 1'b0;
      o_sdram_addr_mux_ctl   <= 1'b0;
    end
    else
    begin
      o_sdram_row_strobe_n <= !(state == S_ROW && cnt == 8'h0);
      o_sdram_col_strobe_n <= !(state == S_COL && cnt == 8'h0);
      o_sdram_write_strobe_n <= !(state == S_COL && cnt == 8'h0 && wr);
      // Row: address bit; column: auto-precharge command bit
      o_sdram_addr_bit_ten <= (state == S_ROW) ? addr[20]
                              : (state == S_COL);
      o_sdram_addr_mux_ctl <= i_ext_master && state == S_COL;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      o_prog_line <= 6'h3f;
    else if (state == S_PROG)
      o_prog_line <= wave_word[5:0];
    else
      o_prog_line <= 6'h3f;
  end

  // Buffer controls and address latch
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_buffer_ctl_zero <= 1'b1;
      o_buffer_ctl_one  <= 1'b1;
      o_addr_latch_en   <= 1'b0;
    end
    else
    begin
      unique case (i_buffer_ctl_config_field)
        `EMC_BCTL_NORMAL:
        begin
          o_buffer_ctl_zero <= !(act && !wr);
          o_buffer_ctl_one  <= !(act && wr);
        end
        `EMC_BCTL_SWAP:
        begin
          o_buffer_ctl_zero <= !(act && wr);
          o_buffer_ctl_one  <= !(act && !wr);
        end
        default:
        begin
          o_buffer_ctl_zero <= 1'b1;
          o_buffer_ctl_one  <= 1'b1;
        end
      endcase
      o_addr_latch_en <= i_ext_master && state == S_IDLE && i_req;
    end
  end
endmodule

//--- emc_asserts.sv
// Concurrent checks on the memory controller pins
module emc_asserts
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic       i_gp_transfer_done_in,
  input  wire logic       o_busy,
  input  wire logic       o_done,
  input  wire logic [7:0] o_chip_sel_n,
  input  wire logic       o_addr_latch_en,
  input  wire logic [7:0] o_gp_write_lane_en_n,
  input  wire logic       o_gp_output_en_n,
  input  wire logic       o_sdram_row_strobe_n,
  input  wire logic       o_sdram_col_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  a_cs_one_hot: assert property ($onehot0(~o_chip_sel_n))
    else $error("several chip selects low");
  a_idle_pins_high: assert property (!o_busy && $past(!o_busy) |->
    &o_chip_sel_n && &o_gp_write_lane_en_n && o_gp_output_en_n)
    else $error("select pins active while idle");
  a_strobe_idle: assert property (!o_busy && $past(!o_busy) |->
    o_sdram_row_strobe_n && o_sdram_col_strobe_n)
    else $error("sdram strobe active while idle");
  a_oe_not_write: assert property (!o_gp_output_en_n |->
    &o_gp_write_lane_en_n)
    else $error("output enable during write");
  a_lane_needs_cs: assert property (!(&o_gp_write_lane_en_n) |->
    !(&o_chip_sel_n))
    else $error("write lane without chip select");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_ale_pulse: assert property (o_addr_latch_en |=> !o_addr_latch_en)
    else $error("latch enable longer than one cycle");
  a_term_done: assert property (o_busy && !i_gp_transfer_done_in &&
    !(o_gp_output_en_n && (&o_gp_write_lane_en_n)) |-> ##[0:2] o_done)
    else $error("termination did not end access");
  a_ras_cas_apart: assert property (!o_sdram_col_strobe_n |->
    o_sdram_row_strobe_n)
    else $error("row and column strobe together");
endmodule

//--- emc_dev_model.sv
// Far-side device: termination pulse and wait stall
module emc_dev_model
(
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_chip_sel_n,
  input  wire logic [7:0] i_prog_lane_select_n,
  input  wire logic [3:0] i_ack_delay,
  input  wire logic [3:0] i_wait_cycles,
  output logic            o_done_n,
  output logic            o_wait
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cs_cnt = 4'h0;
  logic [3:0] wt_cnt = 4'h0;
  always @(posedge i_ref_clk)
  begin
    cs_cnt <= (&i_chip_sel_n) ? 4'h0 : cs_cnt + 4'h1;
    wt_cnt <= (&i_prog_lane_select_n) ? 4'h0 : wt_cnt + {3'h0, o_wait};
  end
  // Pulled up unless a selected access has reached its delay
  assign o_done_n = !(!(&i_chip_sel_n) && cs_cnt == i_ack_delay);
  assign o_wait = !(&i_prog_lane_select_n) && wt_cnt < i_wait_cycles;
endmodule

//--- tb_top.sv
// Self-checking bench for the memory controller pin block
`include "emc_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] addr;
    logic        wr;
    logic [1:0]  size;
    logic [7:0]  lanes;
  } emc_row_t;
  logic [31:0] i_addr = 32'h0;
  logic [8:0]  wave [`EMC_WAVE_DEPTH];
  logic [7:0]  cs_n, wl_n, mask, pls_n, s_cs, s_wl, s_mask, s_pls;
  logic [5:0]  line, s_line;
  logic [3:0]  dly = 4'h1;
  logic [3:0]  wt_n = 4'h0;
  logic [1:0]  size = 2'h0;
  logic [1:0]  bctl = 2'h0;
  logic        b0, b1, s_b0, s_b1;
  logic [1:0]  burst_addr_out, s_burst_addr_out, s_a10;
  logic        i_ref_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        req = 1'b0;
  logic        wr = 1'b0;
  logic        ext = 1'b0;
  logic        done_n, wt, busy, done, ale, oe_n, par_n, ras_n, cas_n;
  logic        we_n, a10, mux, s_oe, s_ras, s_cas, s_we, s_par, s_ale, s_mux;
  int          n_fail = 0;
  int          total_checks = 0;
  int          tick = 0;
  int          c1;
  int          exp_c;
  emc_row_t    rows [5] = '{
    '{32'h0000_0015, 1'b1, 2'h0, 8'h20}, '{32'h6000_000e, 1'b1, 2'h1, 8'hc0},
    '{32'he000_001c, 1'b1, 2'h2, 8'hf0}, '{32'h8000_0000, 1'b0, 2'h3, 8'hff},
    '{32'ha000_000b, 1'b1, 2'h0, 8'h08}};
  emc_core i_dut (.i_ref_clk, .i_reset, .i_req(req), .i_addr, .i_write(wr),
    .i_size(emc_pkg::emc_size_t'(size)), .i_ext_master(ext),
    .i_buffer_ctl_config_field(bctl), .i_bank_machine(16'h0024),
    .i_bank_port_size(16'hffff), .i_parity_en(8'h01), .i_wave_mem(wave),
    .i_gp_transfer_done_in(done_n), .i_prog_wait_in(wt), .o_busy(busy),
    .o_done(done), .o_chip_sel_n(cs_n), .o_buffer_ctl_zero(b0),
    .o_buffer_ctl_one(b1), .o_burst_addr_out(burst_addr_out), .o_addr_latch_en(ale),
    .o_gp_write_lane_en_n(wl_n), .o_sdram_lane_mask(mask),
    .o_prog_lane_select_n(pls_n), .o_sdram_addr_bit_ten(a10),
    .o_prog_line(line), .o_sdram_write_strobe_n(we_n),
    .o_sdram_row_strobe_n(ras_n), .o_sdram_col_strobe_n(cas_n),
    .o_gp_output_en_n(oe_n), .o_parity_lane_select_n(par_n),
    .o_sdram_addr_mux_ctl(mux));
  emc_dev_model i_dev (.i_ref_clk, .i_chip_sel_n(cs_n),
    .i_prog_lane_select_n(pls_n), .i_ack_delay(dly), .i_wait_cycles(wt_n),
    .o_done_n(done_n), .o_wait(wt));
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Issue one transfer and fold its pins until done; burst address and A10 are sampled, not folded
  task automatic xfer(input logic [31:0] ad, input logic w,
                      input logic [1:0] sz);
    @(posedge i_ref_clk);
    req <= 1'b1;
    i_addr <= ad;
    wr <= w;
    size <= sz;
    @(posedge i_ref_clk);
    req <= 1'b0;
    {s_cs, s_wl, s_mask, s_pls, s_line, s_b0, s_b1} = '1;
    {s_oe, s_ras, s_cas, s_we, s_par, s_ale, s_mux, s_a10, s_burst_addr_out} = 11'h7c0;
    c1 = 0;
    do
    begin
      @(negedge i_ref_clk);
      c1++;
      {s_cs, s_wl, s_mask, s_pls} = {s_cs, s_wl, s_mask, s_pls}
                                    & {cs_n, wl_n, mask, pls_n};
      {s_oe, s_ras, s_cas, s_we, s_par} = {s_oe, s_ras, s_cas, s_we, s_par}
                                          & {oe_n, ras_n, cas_n, we_n, par_n};
      {s_ale, s_mux} = {s_ale, s_mux} | {ale, mux};
      {s_b0, s_b1} = {s_b0, s_b1} & {b0, b1};
      if (!ras_n) s_a10[1] = a10;
      if (!cas_n) s_a10[0] = a10;
      if (!(&pls_n)) s_line = s_line & line;
      if (!(&cs_n)) s_burst_addr_out = burst_addr_out;
    end while (done !== 1'b1 && c1 < 400);
    check("done busy", 2'h3, {done, busy});
    @(posedge i_ref_clk);
  endtask
  initial
  begin
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk)
  begin
    tick++;
    if (tick == 20000)
    begin
      n_fail++;
      report_and_stop;
    end
  end
  initial
  begin
    foreach (wave[k]) wave[k] = (k < 3) ? {k == 2, 8'h95} : 9'h100;
    repeat (8) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    @(negedge i_ref_clk);
    check("reset pins", 32'hffff_ff3f, {cs_n, wl_n, mask, 2'h0, line});
    foreach (rows[i])
    begin
      xfer(rows[i].addr, rows[i].wr, rows[i].size);
      check("cs", 8'(~(8'h01 << rows[i].addr[31:29])), s_cs);
      check("wlane", 8'(rows[i].wr ? ~rows[i].lanes : 8'hff), s_wl);
      check("oe", rows[i].wr, s_oe);
      check("parity", rows[i].addr[31:29] != 3'h0, s_par);
      check("burst", rows[i].addr[4:3], s_burst_addr_out);
      check("bctl", {rows[i].wr, !rows[i].wr}, {s_b0, s_b1});
    end
    dly <= 4'h5;
    bctl <= 2'h1;
    xfer(32'h8000_0000, 1'b0, 2'h3);
    check("term delay", 5 + 3, c1);
    check("bctl swap", 2'h2, {s_b0, s_b1});
    ext <= 1'b1;
    xfer(32'h2000_0004, 1'b1, 2'h2);
    check("sdram strobes", 3'h0, {s_ras, s_cas, s_we});
    check("a10", 2'h1, s_a10);
    check("mask", 8'h0f, s_mask);
    check("ale mux", 2'h3, {s_ale, s_mux});
    bctl <= 2'h2;
    xfer(32'h4000_0000, 1'b0, 2'h0);
    check("bctl off", 2'h3, {s_b0, s_b1});
    check("prog length", 3 + 1, c1);
    check("prog line", 6'h15, s_line);
    check("prog lanes", 8'hfe, s_pls);
    wt_n <= 4'h6;
    exp_c = c1 + 6;
    xfer(32'h4000_0000, 1'b0, 2'h0);
    check("wait stall", exp_c, c1);
    report_and_stop;
  end
endmodule
bind emc_core emc_asserts i_chk (.i_ref_clk, .i_reset, .i_gp_transfer_done_in,
  .o_busy, .o_done, .o_chip_sel_n, .o_addr_latch_en, .o_gp_write_lane_en_n,
  .o_gp_output_en_n, .o_sdram_row_strobe_n, .o_sdram_col_strobe_n);
